/* File: rtl/dbat_consts.vh */
// constants for the bank activate timing and strobe mode block
`ifndef DBAT_CONSTS_VH
`define DBAT_CONSTS_VH
// ****************************************
// mode register addresses and fields
// ****************************************
`define DBAT_MA_STROBE_MODE 6'h33
`define DBAT_MA_SET_POINT 6'h0d
`define DBAT_MA_CAPABILITY 6'h00
`define DBAT_BIT_SE_READ 1
`define DBAT_BIT_SE_WRITE 2
`define DBAT_BIT_SE_CLOCK 3
`define DBAT_BIT_SE_SUPPORT 5
`define DBAT_BIT_WRITE_SET_POINT_SELECT 6
`define DBAT_BIT_OPERATING_SET_POINT_SELECT 7
`define DBAT_STROBE_MODE_MASK 8'h0e
`define DBAT_STROBE_MODE_RESET 8'h00
`define DBAT_SE_SUPPORTED 1'b1
// ****************************************
// link timing, given in ns and rounded up to whole link clocks
// ****************************************
`define DBAT_TCK_NS 800
`define DBAT_FOUR_ACTIVATE_WINDOW_NS 40
`define DBAT_BANK_TO_BANK_ACTIVATE_DELAY_NS 10
`define DBAT_BANK_TO_BANK_ACTIVATE_DELAY_MIN_CK 4
`define DBAT_CEIL_CK(ns) (((ns) + `DBAT_TCK_NS - 1) / `DBAT_TCK_NS)
`define DBAT_AT_LEAST_ONE(n) (((n) < 1) ? 1 : (n))
`define DBAT_FOUR_ACTIVATE_WINDOW_CK `DBAT_AT_LEAST_ONE(`DBAT_CEIL_CK(`DBAT_FOUR_ACTIVATE_WINDOW_NS))
`define DBAT_BANK_TO_BANK_ACTIVATE_DELAY_RAW_CK `DBAT_CEIL_CK(`DBAT_BANK_TO_BANK_ACTIVATE_DELAY_NS)
`define DBAT_BANK_TO_BANK_ACTIVATE_DELAY_CK ((`DBAT_BANK_TO_BANK_ACTIVATE_DELAY_RAW_CK > `DBAT_BANK_TO_BANK_ACTIVATE_DELAY_MIN_CK) ? `DBAT_BANK_TO_BANK_ACTIVATE_DELAY_RAW_CK : `DBAT_BANK_TO_BANK_ACTIVATE_DELAY_MIN_CK)
`define DBAT_FAW_COUNT 4
`define DBAT_CNT_W 16
`endif

/* File: rtl/dbat_act_monitor.v */
// activate spacing and rolling window monitor on link clock ticks
`include "dbat_consts.vh"
module dbat_act_monitor (
	// clock and reset
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// events from the command decoder
	input wire link_tick,
	input wire act_pulse,
	// violation pulses
	output reg rrd_violation_reg,
	output reg faw_violation_reg
);
	localparam integer FAW_CK_I = `DBAT_FOUR_ACTIVATE_WINDOW_CK;
	localparam integer RRD_CK_I = `DBAT_BANK_TO_BANK_ACTIVATE_DELAY_CK;
	// counts are small; keep the low bits so compares stay at counter width
	localparam [`DBAT_CNT_W-1:0] FAW_CK = FAW_CK_I[`DBAT_CNT_W-1:0];
	localparam [`DBAT_CNT_W-1:0] RRD_CK = RRD_CK_I[`DBAT_CNT_W-1:0];

	reg [`DBAT_CNT_W-1:0] cycle_reg;
	reg [`DBAT_CNT_W-1:0] hist_reg [0:3];
	reg [2:0] seen_reg;
	integer i;

	// elapsed link clocks, wraps harmlessly as both sides wrap
	function [`DBAT_CNT_W-1:0] age;
		input [`DBAT_CNT_W-1:0] now;
		input [`DBAT_CNT_W-1:0] then_t;
		begin
			age = now - then_t;
		end
	endfunction

	// history of the last four activates, newest in slot 0
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cycle_reg <= {`DBAT_CNT_W{1'b0}};
			seen_reg <= 3'h0;
			rrd_violation_reg <= 1'b0;
			faw_violation_reg <= 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				hist_reg[i] <= {`DBAT_CNT_W{1'b0}};
			end
		end else if (clk_en) begin
			rrd_violation_reg <= 1'b0;
			faw_violation_reg <= 1'b0;
			if (link_tick) begin
				cycle_reg <= cycle_reg + 1'b1;
			end
			if (act_pulse) begin
				rrd_violation_reg <= (seen_reg != 3'h0) && (age(cycle_reg, hist_reg[0]) < RRD_CK);
				faw_violation_reg <= (seen_reg == 3'h4) && (age(cycle_reg, hist_reg[3]) < FAW_CK);
				hist_reg[0] <= cycle_reg;
				for (i = 1; i < 4; i = i + 1) begin
					hist_reg[i] <= hist_reg[i-1];
				end
				if (seen_reg != 3'h4) begin
					seen_reg <= seen_reg + 3'h1;
				end
			end
		end
	end
endmodule // dbat_act_monitor

/* File: rtl/dbat_top.v */
// command decode, bank activation and strobe/clock ended mode control
`include "dbat_consts.vh"
module dbat_top (
	// system clock, reset, enable
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// link clock pins
	input wire true_clock,
	input wire complement_clock,
	// command pins
	input wire chip_select,
	input wire [5:0] command_bits,
	input wire [2:0] bank_address,
	input wire [15:0] row_address,
	input wire [7:0] mode_data,
	// write strobe pins
	input wire write_strobe,
	input wire complement_write_strobe,
	// read strobe source from the data path
	input wire read_strobe_src,
	// read strobe pins
	output reg read_strobe_out,
	output reg complement_strobe_out,
	output reg complement_strobe_oe_b,
	// activation results and write strobe rise
	output reg act_done,
	output reg [2:0] act_bank,
	output reg [15:0] act_row,
	output reg [7:0] bank_open,
	output reg write_strobe_rise,
	// mode and status
	output reg se_read_mode,
	output reg se_write_mode,
	output reg se_clock_mode,
	output reg se_capability,
	output reg rrd_violation,
	output reg faw_violation
);
	// ****************************************
	// state
	// ****************************************
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_ACT1 = 3'b010;
	localparam [2:0] ST_MRW = 3'b100;

	reg [1:0] clk_sync1_reg, clk_sync2_reg;
	reg [1:0] wst_sync1_reg, wst_sync2_reg;
	reg [33:0] pin_sync1_reg, pin_sync2_reg;
	reg link_prev_reg, wst_prev_reg;
	reg [2:0] state_reg, state_next;
	reg [2:0] pend_bank_reg;
	reg [5:0] pend_ma_reg;
	reg [7:0] sp_copy_reg [0:1];
	reg write_set_point_select_reg, operating_set_point_select_reg;
	reg [7:0] active_mode;
	wire link_level, link_tick, wst_level;
	wire cs_s;
	wire [5:0] cmd_s;
	wire [2:0] bank_s;
	wire [15:0] row_s;
	wire [7:0] data_s;
	wire act1_cmd, act2_cmd, mrw_cmd;
	wire mon_rrd, mon_faw;
	reg act_pulse;

	// a command cycle pattern test, used for every decode
	function match;
		input cs;
		input [5:0] cmd;
		input b0;
		input b1;
		begin
			match = cs && (cmd[0] == b0) && (cmd[1] == b1);
		end
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	// every pin is two-flop synchronised; pins move slowly against sys_clk
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_sync1_reg <= 2'h0;
			clk_sync2_reg <= 2'h0;
			wst_sync1_reg <= 2'h0;
			wst_sync2_reg <= 2'h0;
			pin_sync1_reg <= 34'h0;
			pin_sync2_reg <= 34'h0;
		end else if (clk_en) begin
			clk_sync1_reg <= {complement_clock, true_clock};
			clk_sync2_reg <= clk_sync1_reg;
			wst_sync1_reg <= {complement_write_strobe, write_strobe};
			wst_sync2_reg <= wst_sync1_reg;
			pin_sync1_reg <= {mode_data, row_address, bank_address, command_bits, chip_select};
			pin_sync2_reg <= pin_sync1_reg;
		end
	end

	assign cs_s = pin_sync2_reg[0];
	assign cmd_s = pin_sync2_reg[6:1];
	assign bank_s = pin_sync2_reg[9:7];
	assign row_s = pin_sync2_reg[25:10];
	assign data_s = pin_sync2_reg[33:26];

	// single-ended clock ignores the complement pin
	assign link_level = se_clock_mode ? clk_sync2_reg[0] : (clk_sync2_reg[0] & ~clk_sync2_reg[1]);
	assign link_tick = link_level & ~link_prev_reg;
	// single-ended write strobe ignores the complement pin
	assign wst_level = se_write_mode ? wst_sync2_reg[0] : (wst_sync2_reg[0] & ~wst_sync2_reg[1]);

	// ****************************************
	// command decode
	// ****************************************
	// activate halves; the mode write uses the free code 0,1
	assign act1_cmd = link_tick && match(cs_s, cmd_s, 1'b1, 1'b0);
	assign act2_cmd = link_tick && match(cs_s, cmd_s, 1'b1, 1'b1);
	assign mrw_cmd = link_tick && match(cs_s, cmd_s, 1'b0, 1'b1);

	// second half must come on the very next link edge, else dropped
	always @* begin
		state_next = state_reg;
		act_pulse = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (act1_cmd) begin
					state_next = ST_ACT1;
				end else if (mrw_cmd) begin
					state_next = ST_MRW;
				end
			end
			ST_ACT1: begin
				if (link_tick) begin
					act_pulse = act2_cmd;
					state_next = act1_cmd ? ST_ACT1 : ST_IDLE;
				end
			end
			ST_MRW: begin
				if (link_tick) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// operate from the copy named by the operating set point
	always @* begin
		active_mode = operating_set_point_select_reg ? sp_copy_reg[1] : sp_copy_reg[0];
	end

	// ****************************************
	// registers and outputs
	// ****************************************
	// link state, mode storage and activation bookkeeping
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			link_prev_reg <= 1'b0;
			wst_prev_reg <= 1'b0;
			state_reg <= ST_IDLE;
			pend_bank_reg <= 3'h0;
			pend_ma_reg <= 6'h00;
			sp_copy_reg[0] <= `DBAT_STROBE_MODE_RESET;
			sp_copy_reg[1] <= `DBAT_STROBE_MODE_RESET;
			write_set_point_select_reg <= 1'b0;
			operating_set_point_select_reg <= 1'b0;
			act_done <= 1'b0;
			act_bank <= 3'h0;
			act_row <= 16'h0000;
			bank_open <= 8'h00;
			write_strobe_rise <= 1'b0;
		end else if (clk_en) begin
			link_prev_reg <= link_level;
			wst_prev_reg <= wst_level;
			state_reg <= state_next;
			write_strobe_rise <= wst_level & ~wst_prev_reg;
			act_done <= act_pulse;
			if (act1_cmd) begin
				pend_bank_reg <= bank_s;
			end
			// mode address rides the first cycle, data the second
			if (mrw_cmd) begin
				pend_ma_reg <= row_s[5:0];
			end
			if (state_reg == ST_MRW && link_tick) begin
				// only 33h holds the strobe modes, reserved bits kept zero
				if (pend_ma_reg == `DBAT_MA_STROBE_MODE) begin
					// only the selected set point copy changes
					sp_copy_reg[write_set_point_select_reg] <= data_s & `DBAT_STROBE_MODE_MASK;
				end
				if (pend_ma_reg == `DBAT_MA_SET_POINT) begin
					write_set_point_select_reg <= data_s[`DBAT_BIT_WRITE_SET_POINT_SELECT];
					operating_set_point_select_reg <= data_s[`DBAT_BIT_OPERATING_SET_POINT_SELECT];
				end
			end
			if (act_pulse) begin
				// bank from first half, row opened in that bank
				act_bank <= pend_bank_reg;
				act_row <= row_s;
				bank_open[pend_bank_reg] <= 1'b1;
			end
		end
	end

	// mode pins and read strobe pins
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			se_read_mode <= 1'b0;
			se_write_mode <= 1'b0;
			se_clock_mode <= 1'b0;
			se_capability <= 1'b0;
			read_strobe_out <= 1'b0;
			complement_strobe_out <= 1'b0;
			complement_strobe_oe_b <= 1'b1;
			rrd_violation <= 1'b0;
			faw_violation <= 1'b0;
		end else if (clk_en) begin
			se_read_mode <= active_mode[`DBAT_BIT_SE_READ];
			se_write_mode <= active_mode[`DBAT_BIT_SE_WRITE];
			se_clock_mode <= active_mode[`DBAT_BIT_SE_CLOCK];
			se_capability <= `DBAT_SE_SUPPORTED;
			read_strobe_out <= read_strobe_src;
			// complement held low in single-ended read mode rather than toggling
			complement_strobe_out <= se_read_mode ? 1'b0 : ~read_strobe_src;
			complement_strobe_oe_b <= 1'b0;
			rrd_violation <= mon_rrd;
			faw_violation <= mon_faw;
		end
	end

	// ****************************************
	// activate spacing monitor
	// ****************************************
	// flags controller slips; the device itself never refuses an activate
	dbat_act_monitor u_mon (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.link_tick(link_tick),
		.act_pulse(act_pulse),
		.rrd_violation_reg(mon_rrd),
		.faw_violation_reg(mon_faw)
	);
endmodule // dbat_top

/* File: sim/dbat_top_props.sv */
// assertion checker for the bank activate and strobe mode block
module dbat_top_props (
	// clock and reset
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// watched pins
	input wire read_strobe_src,
	input wire read_strobe_out,
	input wire complement_strobe_out,
	input wire complement_strobe_oe_b,
	input wire act_done,
	input wire [2:0] act_bank,
	input wire [15:0] act_row,
	input wire [7:0] bank_open,
	input wire se_read_mode,
	input wire se_capability,
	input wire rrd_violation
);
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_cap_shown: assert property ($past(rst_b) && $past(clk_en) |-> se_capability)
		else $error("capability bit not set");
	a_oe_driving: assert property ($past(rst_b) && $past(clk_en) |-> !complement_strobe_oe_b)
		else $error("complement strobe not driven");
	a_rd_follows: assert property ($past(rst_b) && $past(clk_en)
		|-> read_strobe_out == $past(read_strobe_src))
		else $error("read strobe does not follow source");
	// mode must be settled a cycle, the stored copy leads the mode pin by one
	a_cmp_diff: assert property (!se_read_mode && !$past(se_read_mode) && $past(clk_en)
		&& $past(rst_b) |-> complement_strobe_out == !$past(read_strobe_src))
		else $error("complement strobe not inverse");
	a_cmp_low: assert property (se_read_mode && $past(se_read_mode) && $past(clk_en)
		|-> !complement_strobe_out)
		else $error("complement strobe not low");
	// a frozen clock enable may hold a pulse, so only running cycles count
	a_done_pulse: assert property (act_done && clk_en |=> !act_done)
		else $error("activate done longer than one cycle");
	a_open_new: assert property (act_done
		|-> bank_open == ($past(bank_open) | (8'h01 << act_bank)))
		else $error("open bank map wrong");
	a_act_hold: assert property (!act_done && $past(rst_b)
		|-> $stable(act_bank) && $stable(act_row))
		else $error("bank or row moved without activate");
	a_rrd_pulse: assert property (rrd_violation && clk_en |=> !rrd_violation)
		else $error("spacing flag longer than one cycle");
endmodule // dbat_top_props

bind dbat_top dbat_top_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
	.read_strobe_src(read_strobe_src), .read_strobe_out(read_strobe_out),
	.complement_strobe_out(complement_strobe_out),
	.complement_strobe_oe_b(complement_strobe_oe_b), .act_done(act_done),
	.act_bank(act_bank), .act_row(act_row), .bank_open(bank_open),
	.se_read_mode(se_read_mode), .se_capability(se_capability),
	.rrd_violation(rrd_violation));

/* File: sim/dbat_host_model.sv */
// memory controller model driving the link clock and command pins
module dbat_host_model (
	// paces the link
	input wire sys_clk,
	// link pins
	output logic true_clock,
	output logic complement_clock,
	output logic chip_select,
	output logic [5:0] command_bits,
	output logic [2:0] bank_address,
	output logic [15:0] row_address,
	output logic [7:0] mode_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// link cycles
	// ****************
	// pinning the complement high only works in true-clock-only mode
	logic comp_fixed = 1'b0;
	// link clock stands still low between frames
	initial begin
		true_clock = 1'b0;
		complement_clock = 1'b1;
		chip_select = 1'b0;
		command_bits = 6'h00;
		bank_address = 3'h0;
		row_address = 16'h0000;
		mode_data = 8'h00;
	end
	// no precharge or refresh issued
	// called on a falling edge; lines lead the rise by 300 ns, period is 800 ns
	task link_cycle(input logic cs, input logic [5:0] cmd, input logic [2:0] ba,
		input logic [15:0] ra, input logic [7:0] md);
		chip_select = cs;
		command_bits = cmd;
		bank_address = ba;
		row_address = ra;
		mode_data = md;
		repeat (3) @(negedge sys_clk);
		true_clock = 1'b1;
		// complement kept at a valid level
		complement_clock = comp_fixed;
		repeat (4) @(negedge sys_clk);
		true_clock = 1'b0;
		complement_clock = 1'b1;
		// released lines never keep a stale value
		chip_select = 1'b0;
		command_bits = ~cmd;
		bank_address = ~ba;
		row_address = ~ra;
		mode_data = ~md;
		@(negedge sys_clk);
	endtask
endmodule // dbat_host_model

/* File: sim/tb_dbat_top.sv */
// self-checking bench for the bank activate and strobe mode block
module tb_dbat_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// harness
	// ****************
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic write_strobe = 1'b0;
	logic complement_write_strobe = 1'b1;
	logic read_strobe_src = 1'b0;
	wire true_clock, complement_clock, chip_select, act_done, read_strobe_out;
	wire complement_strobe_out, complement_strobe_oe_b, write_strobe_rise, se_read_mode;
	wire se_write_mode, se_clock_mode, se_capability, rrd_violation, faw_violation;
	wire [5:0] command_bits;
	wire [2:0] bank_address, act_bank;
	wire [15:0] row_address, act_row;
	wire [7:0] mode_data, bank_open;
	int fail_count = 0;
	int num_checks = 0;
	int n_done = 0;
	int n_rrd = 0;
	int n_wsr = 0;
	int n_faw = 0;
	dbat_host_model host (.sys_clk, .true_clock, .complement_clock, .chip_select,
		.command_bits, .bank_address, .row_address, .mode_data);
	dbat_top dut (.sys_clk, .rst_b, .clk_en, .true_clock, .complement_clock,
		.chip_select, .command_bits, .bank_address, .row_address, .mode_data,
		.write_strobe, .complement_write_strobe, .read_strobe_src, .read_strobe_out,
		.complement_strobe_out, .complement_strobe_oe_b, .act_done, .act_bank, .act_row,
		.bank_open, .write_strobe_rise, .se_read_mode, .se_write_mode, .se_clock_mode,
		.se_capability, .rrd_violation, .faw_violation);
	always #50 sys_clk = ~sys_clk;
	// pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge sys_clk) begin
		if (act_done === 1'b1) n_done++;
		if (rrd_violation === 1'b1) n_rrd++;
		if (faw_violation === 1'b1) n_faw++;
		if (write_strobe_rise === 1'b1) n_wsr++;
	end
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task act(input logic [2:0] b, input logic [15:0] r);
		host.link_cycle(1'b1, 6'h01, b, 16'h0000, 8'h00);
		host.link_cycle(1'b1, 6'h03, 3'h0, r, 8'h00);
		repeat (4) @(negedge sys_clk);
	endtask
	task mode_register_write(input logic [5:0] a, input logic [7:0] d);
		host.link_cycle(1'b1, 6'h02, 3'h0, {10'h000, a}, 8'h00);
		host.link_cycle(1'b0, 6'h00, 3'h0, 16'h0000, d);
		repeat (6) @(negedge sys_clk);
	endtask
	task idle(input int n);
		repeat (n) host.link_cycle(1'b0, 6'h00, 3'h0, 16'h0000, 8'h00);
	endtask
	task modes(input logic [2:0] e);
		chk("modes", e, {se_clock_mode, se_write_mode, se_read_mode});
	endtask
	// fixed complement level means a single-ended write strobe
	task ws_pulse(input logic cws);
		write_strobe = 1'b1;
		complement_write_strobe = cws;
		repeat (4) @(negedge sys_clk);
		write_strobe = 1'b0;
		complement_write_strobe = 1'b1;
		repeat (4) @(negedge sys_clk);
	endtask
	// ****************
	// scenarios
	// ****************
	task t_reset;
		modes(3'h0);
		chk("capability", 1'b1, se_capability);
		chk("strobe_oe_b", 1'b0, complement_strobe_oe_b);
		$display("done reset values");
	endtask
	task t_act;
		idle(4);
		act(3'h5, 16'h1234);
		chk("done count", 1, n_done);
		chk("act_bank", 3'h5, act_bank);
		chk("act_row", 16'h1234, act_row);
		idle(4);
		act(3'h2, 16'hbeef);
		chk("bank_open", 8'h24, bank_open);
		chk("spaced rrd count", 0, n_rrd);
		act(3'h1, 16'h0001);
		chk("tight rrd count", 1, n_rrd);
		chk("done count", 3, n_done);
		$display("done activate");
	endtask
	task t_pair;
		host.link_cycle(1'b1, 6'h01, 3'h3, 16'h0000, 8'h00);
		idle(1);
		host.link_cycle(1'b1, 6'h03, 3'h0, 16'h5555, 8'h00);
		repeat (4) @(negedge sys_clk);
		chk("split pair count", 3, n_done);
		chk("act_bank kept", 3'h1, act_bank);
		// a second first half restarts the pair with its own bank
		host.link_cycle(1'b1, 6'h01, 3'h3, 16'h0000, 8'h00);
		act(3'h4, 16'h4444);
		chk("restart pair count", 4, n_done);
		chk("restart bank", 3'h4, act_bank);
		$display("done split pair");
	endtask
	task t_modes;
		mode_register_write(6'h33, 8'hff);
		modes(3'h7);
		chk("complement low", 1'b0, complement_strobe_out);
		read_strobe_src = 1'b1;
		@(negedge sys_clk);
		chk("read strobe se", 1'b1, read_strobe_out);
		chk("complement se", 1'b0, complement_strobe_out);
		read_strobe_src = 1'b0;
		ws_pulse(1'b1);
		chk("se write rises", 1, n_wsr);
		host.comp_fixed = 1'b1;
		act(3'h6, 16'h0606);
		chk("true clock only row", 16'h0606, act_row);
		// exactly four link clocks since the last activate is allowed
		chk("boundary rrd count", 1, n_rrd);
		host.comp_fixed = 1'b0;
		mode_register_write(6'h0d, 8'h40);
		mode_register_write(6'h33, 8'h00);
		modes(3'h7);
		mode_register_write(6'h0d, 8'hc0);
		modes(3'h0);
		mode_register_write(6'h0d, 8'h00);
		modes(3'h7);
		mode_register_write(6'h33, 8'h00);
		mode_register_write(6'h20, 8'hff);
		modes(3'h0);
		chk("complement inverse", 1'b1, complement_strobe_out);
		read_strobe_src = 1'b1;
		@(negedge sys_clk);
		chk("complement diff", 1'b0, complement_strobe_out);
		read_strobe_src = 1'b0;
		ws_pulse(1'b0);
		chk("diff write rises", 2, n_wsr);
		$display("done mode register");
	endtask
	// a whole activate while the enable is low must leave no trace
	task t_freeze;
		clk_en = 1'b0;
		act(3'h7, 16'h7777);
		clk_en = 1'b1;
		idle(1);
		chk("frozen count", 5, n_done);
		chk("frozen bank", 3'h6, act_bank);
		chk("frozen open", 8'h76, bank_open);
		chk("faw count", 0, n_faw);
		$display("done clock enable");
	endtask
	// hang guard, far beyond the normal run
	initial begin
		#1000000;
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (2) @(negedge sys_clk);
		t_reset;
		t_act;
		t_pair;
		t_modes;
		t_freeze;
		give_verdict;
	end
endmodule // tb_dbat_top
